// File: load_store_exclusive_exec_tb.sv
`timescale 1ns/100ps
`default_nettype none
module load_store_exclusive_exec_tb
  import lsx_pkg::*;
;
  logic CLK, RST_N, REQ_VALID, REQ_READY, DECODE_FAULT, MEM_VALID, MEM_READY;
  logic RDATA_VALID, SNOOP_VALID, BRANCH_VALID, FLAGS_WRITE, DONE;
  req_t REQ;
  mem_req_t MEM_REQ;
  logic [2*XLEN-1:0] RDATA;
  logic [XLEN-1:0] SNOOP_ADDR, BRANCH_TARGET, maddr;
  wb_t WB_BASE, WB_DATA, WB_DATA2;
  logic [3:0] stall;
  int n_fail, n_tests, cyc;
  lsx_exec u_lsx_exec (.CLK(CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ(REQ), .DECODE_FAULT(DECODE_FAULT), .MEM_VALID(MEM_VALID), .MEM_READY(MEM_READY),
    .MEM_REQ(MEM_REQ), .RDATA_VALID(RDATA_VALID), .RDATA(RDATA), .SNOOP_VALID(SNOOP_VALID),
    .SNOOP_ADDR(SNOOP_ADDR), .WB_BASE(WB_BASE), .WB_DATA(WB_DATA), .WB_DATA2(WB_DATA2),
    .BRANCH_VALID(BRANCH_VALID), .BRANCH_TARGET(BRANCH_TARGET), .FLAGS_WRITE(FLAGS_WRITE),
    .DONE(DONE));
  lsx_mem_model u_lsx_mem_model (.clk(CLK), .rst_n(RST_N), .mem_valid(MEM_VALID),
    .mem_ready(MEM_READY), .mem_req(MEM_REQ), .rdata_valid(RDATA_VALID), .rdata(RDATA),
    .stall(stall));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic req_t mk(op_t o, size_t s, logic sg, amode_t m, int ofs, logic [31:0] b);
    return '{o, s, sg, m, 13'(ofs), 4'h1, 4'h2, 4'h3, 4'h4,
             b, 32'hCAFE_0001, 32'hCAFE_0002};
  endfunction
  task automatic run(input req_t q);
    int i;
    maddr = '1;
    while (REQ_READY !== 1'b1) @(negedge CLK);
    REQ = q;
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    for (i = 0; i < 40 && DONE !== 1'b1 && BRANCH_VALID !== 1'b1; i++) begin
      if (MEM_VALID === 1'b1 && maddr === '1) maddr = MEM_REQ.addr;
      @(negedge CLK);
    end
    if (i == 40) chk("done", 1, 0);
  endtask
  task automatic t_index();
    stall = 4'h2;
    run(mk(OP_STORE, SZ_WORD, 0, AM_PRE, -8, 32'h0000_0100));
    chk("pre addr", 32'hF8, maddr);
    chk("pre wb", {1'b1, 4'h1, 32'h0000_00F8}, WB_BASE);
    chk("stored", 32'hCAFE_0001, u_lsx_mem_model.mem[62]);
    stall = 4'h0;
    run(mk(OP_LOAD, SZ_WORD, 0, AM_POST, 255, 32'h0000_0040));
    chk("post addr", 32'h40, maddr);
    chk("post wb", {1'b1, 4'h1, 32'h0000_013F}, WB_BASE);
    chk("post data", {1'b1, 4'h2, 32'h1234_5678}, WB_DATA);
  endtask
  task automatic t_sizes();
    run(mk(OP_LOAD, SZ_BYTE, 1, AM_OFFSET, 32, 32'h0));
    chk("sbyte", {1'b1, 4'h2, 32'hFFFF_FF80}, WB_DATA);
    run(mk(OP_LOAD, SZ_BYTE, 0, AM_OFFSET, 32, 32'h0));
    chk("ubyte", {1'b1, 4'h2, 32'h0000_0080}, WB_DATA);
    run(mk(OP_LOAD, SZ_HALF, 1, AM_OFFSET, -4, 32'h28));
    chk("shalf", {1'b1, 4'h2, 32'hFFFF_8001}, WB_DATA);
    run(mk(OP_LOAD, SZ_DUAL, 0, AM_OFFSET, 1020, 32'hFFFF_FC34));
    chk("dual addr", 32'h30, maddr);
    chk("dual lo", {1'b1, 4'h2, 32'h1111_0000}, WB_DATA);
    chk("dual hi", {1'b1, 4'h3, 32'h2222_0000}, WB_DATA2);
  endtask
  task automatic t_ranges();
    int ofs[7] = '{4095, -256, 256, 1022, -1024, -1020, -255};
    size_t sz[7] = '{SZ_BYTE, SZ_WORD, SZ_HALF, SZ_DUAL, SZ_DUAL, SZ_DUAL, SZ_BYTE};
    amode_t am[7] = '{AM_OFFSET, AM_OFFSET, AM_PRE, AM_POST, AM_PRE, AM_POST, AM_POST};
    logic bad[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    for (int k = 0; k < 7; k++) begin
      run(mk(OP_STORE, sz[k], 0, am[k], ofs[k], 32'h0000_2000));
      chk("fault", bad[k], DECODE_FAULT);
    end
    chk("dual st hi", 32'hCAFE_0002, u_lsx_mem_model.mem[1]);
  endtask
  task automatic t_branch();
    req_t q;
    q = mk(OP_LOAD, SZ_WORD, 0, AM_OFFSET, 16, 32'h0);
    q.data_reg = REG_PC;
    run(q);
    chk("branch", 1, BRANCH_VALID);
    chk("target", 32'h0000_1234, BRANCH_TARGET);
  endtask
  task automatic t_excl();
    stall = 4'h3;
    run(mk(OP_LOAD_EXCL, SZ_WORD, 0, AM_OFFSET, 1020, 32'hFFFF_FC54));
    chk("xld addr", 32'h50, maddr);
    chk("xld data", {1'b1, 4'h2, 32'h5555_AAAA}, WB_DATA);
    run(mk(OP_STORE_EXCL, SZ_WORD, 0, AM_OFFSET, 0, 32'h50));
    chk("xst ok", {1'b1, 4'h4, STATUS_OK}, WB_DATA);
    chk("xst mem", 32'hCAFE_0001, u_lsx_mem_model.mem[20]);
    run(mk(OP_STORE_EXCL, SZ_WORD, 0, AM_OFFSET, 0, 32'h50));
    chk("xst again", {1'b1, 4'h4, STATUS_FAIL}, WB_DATA);
    run(mk(OP_LOAD_EXCL, SZ_HALF, 0, AM_OFFSET, 0, 32'h50));
    SNOOP_ADDR = 32'h50;
    SNOOP_VALID = 1'b1;
    @(negedge CLK);
    SNOOP_VALID = 1'b0;
    repeat (3) @(negedge CLK);
    run(mk(OP_STORE_EXCL, SZ_HALF, 0, AM_OFFSET, 0, 32'h50));
    chk("xst snooped", {1'b1, 4'h4, STATUS_FAIL}, WB_DATA);
    run(mk(OP_LOAD_EXCL, SZ_BYTE, 0, AM_OFFSET, 4, 32'h50));
    chk("xofs", 1, DECODE_FAULT);
  endtask
  // A reset between the exclusive pair must drop the reservation.
  task automatic t_reset();
    run(mk(OP_LOAD_EXCL, SZ_WORD, 0, AM_OFFSET, 0, 32'h50));
    RST_N = 1'b0;
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    run(mk(OP_STORE_EXCL, SZ_WORD, 0, AM_OFFSET, 0, 32'h50));
    chk("rst xst", {1'b1, 4'h4, STATUS_FAIL}, WB_DATA);
  endtask
  initial begin
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    RST_N = 1'b0;
    REQ_VALID = 1'b0;
    REQ = '0;
    SNOOP_VALID = 1'b0;
    SNOOP_ADDR = '0;
    stall = 4'h0;
    u_lsx_mem_model.mem[4] = 32'h0000_1235;
    u_lsx_mem_model.mem[8] = 32'h0000_0080;
    u_lsx_mem_model.mem[9] = 32'h0000_8001;
    u_lsx_mem_model.mem[12] = 32'h1111_0000;
    u_lsx_mem_model.mem[13] = 32'h2222_0000;
    u_lsx_mem_model.mem[16] = 32'h1234_5678;
    u_lsx_mem_model.mem[20] = 32'h5555_AAAA;
    repeat (10) @(negedge CLK);
    RST_N = 1'b1;
    t_index();
    t_sizes();
    t_ranges();
    t_branch();
    t_excl();
    t_reset();
    give_verdict();
  end
endmodule
bind lsx_exec lsx_exec_properties u_lsx_exec_properties (.CLK(CLK), .RST_N(RST_N),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ), .DECODE_FAULT(DECODE_FAULT),
  .MEM_VALID(MEM_VALID), .MEM_READY(MEM_READY), .MEM_REQ(MEM_REQ),
  .BRANCH_VALID(BRANCH_VALID), .BRANCH_TARGET(BRANCH_TARGET), .FLAGS_WRITE(FLAGS_WRITE));
`default_nettype wire

// File: lsx_exec.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// RL1: Pre-indexed: address is base plus offset, and that sum is written back.
// RL2: Post-indexed: address is the plain base, then base plus offset is written back.
// RL3: Byte, halfword, word and doubleword; byte and halfword loads sign or zero extend.
// RL4: Single transfers: offset -255..4095 plain, -255..255 when indexed.
// RL5: Doubleword offsets are multiples of four within -1020..1020 in every form.
// RL6: Software keeps SP/PC loads word-only, distinct pair targets, base not a target.
// RL7: Word load to PC branches to value with bit 0 cleared.
// RL8: Software never stores from or bases on PC; SP source only for words.
// RL9: None of these instructions alters the condition flags.
// RL10: Exclusive loads read byte, half or word; no offset means base address.
// RL11: Exclusive store writes status 0 if stored, 1 if not.
// RL12: Status 0 only when no other agent touched the location since the load. Code sees snoops two cycles late, so a store accepted meanwhile still gets 0.
// RL13: Software stores exclusive to the address of the latest exclusive load.
// RL14: Software pairs exclusive store size with the preceding exclusive load.
// RL15: Software avoids PC, SP as status/data, and status equal to data or base.
// RL16: Word exclusive offsets are multiples of four in 0..1020; others have none.
// RL17: Software keeps the code between the exclusive pair short.
// RL18: Exclusive load sets the local monitor; any exclusive store clears it. Code clears it only on a legal exclusive store, not on a faulting one.
module lsx_exec
  import lsx_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire req_t REQ,
  output logic DECODE_FAULT,
  output logic MEM_VALID,
  input wire logic MEM_READY,
  output mem_req_t MEM_REQ,
  input wire logic RDATA_VALID,
  input wire logic [2*XLEN-1:0] RDATA,
  input wire logic SNOOP_VALID,
  input wire logic [XLEN-1:0] SNOOP_ADDR,
  output wb_t WB_BASE,
  output wb_t WB_DATA,
  output wb_t WB_DATA2,
  output logic BRANCH_VALID,
  output logic [XLEN-1:0] BRANCH_TARGET,
  output logic FLAGS_WRITE,
  output logic DONE
);

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} state_t;

  state_t state_q;
  req_t cur_q;
  logic [XLEN-1:0] addr_q;
  logic [XLEN-1:0] base_next_q;
  logic snoop_q1, snoop_q2;
  logic [XLEN-1:0] snoop_addr_q1, snoop_addr_q2;
  logic mon_open;
  logic legal;
  logic accept;
  logic [XLEN-1:0] ofs_ext, sum, acc_addr;
  logic mon_set, mon_clr, excl_ok;
  wb_t wb_base_q, wb_data_q, wb_data2_q;
  logic branch_q, done_q, fault_q;
  logic [XLEN-1:0] branch_tgt_q;

  function automatic logic in_range(input logic signed [IMM_W-1:0] v,
                                    input logic signed [IMM_W-1:0] lo,
                                    input logic signed [IMM_W-1:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [XLEN-1:0] extend(input logic [XLEN-1:0] v, input size_t sz,
                                             input logic sgn);
    case (sz)
      SZ_BYTE: extend = {{24{sgn & v[7]}}, v[7:0]};
      SZ_HALF: extend = {{16{sgn & v[15]}}, v[15:0]};
      default: extend = v;
    endcase
  endfunction

  always_comb begin
    legal = 1'b0;
    case (REQ.op)
      OP_LOAD, OP_STORE: begin
        if (REQ.size == SZ_DUAL) begin
          legal = (REQ.offset[1:0] == 2'b00) &&
                  in_range(REQ.offset, OFS_DUAL_MIN, OFS_DUAL_MAX); // RL5
        end else if (REQ.amode == AM_OFFSET) begin
          legal = in_range(REQ.offset, OFS_PLAIN_MIN, OFS_PLAIN_MAX); // RL4
        end else begin
          legal = in_range(REQ.offset, OFS_INDEX_MIN, OFS_INDEX_MAX); // RL4
        end
      end
      OP_LOAD_EXCL, OP_STORE_EXCL: begin
        if (REQ.size == SZ_WORD) begin
          legal = (REQ.amode == AM_OFFSET) && (REQ.offset[1:0] == 2'b00) &&
                  in_range(REQ.offset, OFS_EXCL_MIN, OFS_EXCL_MAX); // RL16
        end else begin
          legal = (REQ.amode == AM_OFFSET) && (REQ.offset == '0) &&
                  (REQ.size != SZ_DUAL); // RL16
        end
      end
      default: legal = 1'b0;
    endcase
  end

  assign REQ_READY = (state_q == ST_IDLE);
  assign accept = REQ_VALID && REQ_READY;
  assign ofs_ext = {{(XLEN-IMM_W){REQ.offset[IMM_W-1]}}, REQ.offset};
  assign sum = REQ.base_val + ofs_ext;
  assign acc_addr = (REQ.amode == AM_POST) ? REQ.base_val : sum; // RL1 RL2 RL10

  // A store exclusive succeeds only while the reservation still stands.
  assign excl_ok = mon_open; // RL12
  assign mon_set = (state_q == ST_WAIT) && RDATA_VALID && (cur_q.op == OP_LOAD_EXCL); // RL18
  assign mon_clr = accept && legal && (REQ.op == OP_STORE_EXCL); // RL18

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      snoop_q1 <= 1'b0;
      snoop_q2 <= 1'b0;
      snoop_addr_q1 <= RESET_WORD;
      snoop_addr_q2 <= RESET_WORD;
    end else begin
      snoop_q1 <= SNOOP_VALID;
      snoop_q2 <= snoop_q1;
      snoop_addr_q1 <= SNOOP_ADDR;
      snoop_addr_q2 <= snoop_addr_q1;
    end
  end

  lsx_monitor u_monitor (
    .clk(CLK),
    .rst_n(RST_N),
    .set(mon_set),
    .set_addr(addr_q),
    .set_size(cur_q.size),
    .clr(mon_clr),
    .snoop_valid(snoop_q2),
    .snoop_addr(snoop_addr_q2),
    .open(mon_open),
    .addr(),
    .size()
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && legal && !(REQ.op == OP_STORE_EXCL && !excl_ok)) begin
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (MEM_READY) begin
            state_q <= (cur_q.op == OP_LOAD || cur_q.op == OP_LOAD_EXCL) ? ST_WAIT : ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (RDATA_VALID) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_q <= '0;
      addr_q <= RESET_WORD;
      base_next_q <= RESET_WORD;
    end else if (accept) begin
      cur_q <= REQ;
      addr_q <= acc_addr;
      base_next_q <= sum;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wb_base_q <= '0;
      wb_data_q <= '0;
      wb_data2_q <= '0;
      branch_q <= 1'b0;
      branch_tgt_q <= RESET_WORD;
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      wb_base_q.wr_en <= 1'b0;
      wb_data_q.wr_en <= 1'b0;
      wb_data2_q.wr_en <= 1'b0;
      branch_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      if (accept && !legal) begin
        fault_q <= 1'b1;
        done_q <= 1'b1;
      end else if (accept && REQ.op == OP_STORE_EXCL && !excl_ok) begin
        wb_data_q <= '{wr_en: 1'b1, idx: REQ.status_reg, val: STATUS_FAIL}; // RL11
        done_q <= 1'b1;
      end else if (state_q == ST_ISSUE && MEM_READY && cur_q.op != OP_LOAD &&
                   cur_q.op != OP_LOAD_EXCL) begin
        if (cur_q.op == OP_STORE_EXCL) begin
          wb_data_q <= '{wr_en: 1'b1, idx: cur_q.status_reg, val: STATUS_OK}; // RL11
        end
        if (cur_q.amode != AM_OFFSET && cur_q.op == OP_STORE) begin
          wb_base_q <= '{wr_en: 1'b1, idx: cur_q.base_reg, val: base_next_q}; // RL1 RL2
        end
        done_q <= 1'b1;
      end else if (state_q == ST_WAIT && RDATA_VALID) begin
        if (cur_q.op == OP_LOAD && cur_q.size == SZ_WORD && cur_q.data_reg == REG_PC) begin
          branch_q <= 1'b1; // RL7
          branch_tgt_q <= {RDATA[XLEN-1:1], 1'b0}; // RL7
        end else begin
          wb_data_q <= '{wr_en: 1'b1, idx: cur_q.data_reg,
                         val: extend(RDATA[XLEN-1:0], cur_q.size, cur_q.sign_ext)}; // RL3 RL10
        end
        if (cur_q.size == SZ_DUAL) begin
          wb_data2_q <= '{wr_en: 1'b1, idx: cur_q.second_data_reg,
                          val: RDATA[2*XLEN-1:XLEN]}; // RL3
        end
        if (cur_q.amode != AM_OFFSET && cur_q.op == OP_LOAD) begin
          wb_base_q <= '{wr_en: 1'b1, idx: cur_q.base_reg, val: base_next_q}; // RL1 RL2
        end
        done_q <= 1'b1;
      end
    end
  end

  assign MEM_VALID = (state_q == ST_ISSUE);
  always_comb begin
    MEM_REQ.addr = addr_q;
    MEM_REQ.write = (cur_q.op == OP_STORE) || (cur_q.op == OP_STORE_EXCL);
    MEM_REQ.size = cur_q.size;
    MEM_REQ.wdata = {cur_q.second_data_val, cur_q.data_val};
  end

  assign WB_BASE = wb_base_q;
  assign WB_DATA = wb_data_q;
  assign WB_DATA2 = wb_data2_q;
  assign BRANCH_VALID = branch_q;
  assign BRANCH_TARGET = branch_tgt_q;
  assign FLAGS_WRITE = 1'b0; // RL9
  assign DONE = done_q;
  assign DECODE_FAULT = fault_q;

endmodule
`default_nettype wire

// File: lsx_exec_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lsx_exec_properties
  import lsx_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire req_t REQ,
  input wire logic DECODE_FAULT,
  input wire logic MEM_VALID,
  input wire logic MEM_READY,
  input wire mem_req_t MEM_REQ,
  input wire logic BRANCH_VALID,
  input wire logic [XLEN-1:0] BRANCH_TARGET,
  input wire logic FLAGS_WRITE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic take, single, in_rng;
  logic [XLEN-1:0] sum;
  assign take = REQ_VALID && REQ_READY;
  assign single = REQ.op inside {OP_LOAD, OP_STORE} && REQ.size != SZ_DUAL;
  assign in_rng = $signed(REQ.offset) >= OFS_INDEX_MIN && $signed(REQ.offset) <= OFS_INDEX_MAX;
  assign sum = REQ.base_val + {{(XLEN-IMM_W){REQ.offset[IMM_W-1]}}, REQ.offset};
  a_pre_index_addr: assert property (
    take && single && in_rng && REQ.amode == AM_PRE |=> MEM_VALID && MEM_REQ.addr == $past(sum))
    else $error("pre-index address wrong");
  a_post_index_addr: assert property (
    take && single && in_rng && REQ.amode == AM_POST
    |=> MEM_VALID && MEM_REQ.addr == $past(REQ.base_val))
    else $error("post-index address wrong");
  a_mem_req_held: assert property (
    MEM_VALID && !MEM_READY |=> MEM_VALID && $stable(MEM_REQ))
    else $error("bus request dropped or changed before accept");
  a_index_range_fault: assert property (
    take && single && REQ.amode != AM_OFFSET && !in_rng |=> DECODE_FAULT)
    else $error("indexed offset out of range accepted");
  a_dual_align_fault: assert property (
    take && REQ.op inside {OP_LOAD, OP_STORE} && REQ.size == SZ_DUAL && REQ.offset[1:0] != 2'h0
    |=> DECODE_FAULT)
    else $error("unaligned doubleword offset accepted");
  a_excl_offset_fault: assert property (
    take && REQ.op inside {OP_LOAD_EXCL, OP_STORE_EXCL} && REQ.size != SZ_WORD
    && REQ.offset != '0 |=> DECODE_FAULT)
    else $error("offset on byte or half exclusive accepted");
  a_branch_bit_clear: assert property (
    BRANCH_VALID |-> !BRANCH_TARGET[0])
    else $error("branch target bit 0 set");
  a_flags_untouched: assert property (
    !FLAGS_WRITE)
    else $error("condition flags written");
  c_fault: cover property (DECODE_FAULT);
  c_branch: cover property (BRANCH_VALID);
  c_stall: cover property (MEM_VALID && !MEM_READY);
endmodule
`default_nettype wire

// File: lsx_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module lsx_mem_model
  import lsx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_valid,
  output logic mem_ready,
  input wire mem_req_t mem_req,
  output logic rdata_valid,
  output logic [2*XLEN-1:0] rdata,
  input wire logic [3:0] stall
);
  logic [XLEN-1:0] mem [0:63];
  logic [3:0] cnt_q;
  logic [5:0] idx;
  assign idx = mem_req.addr[7:2];
  assign mem_ready = mem_valid && cnt_q == stall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      rdata_valid <= 1'b0;
      rdata <= '0;
    end else begin
      cnt_q <= (mem_valid && !mem_ready) ? cnt_q + 4'h1 : 4'h0;
      rdata_valid <= mem_ready && !mem_req.write;
      // Outside a read answer the data lines toggle so stale data never looks valid.
      rdata <= (mem_ready && !mem_req.write) ? {mem[idx+6'h1], mem[idx]} : ~rdata;
    end
  end
  // Narrow stores write the whole word; tests only read back word and doubleword stores.
  always @(posedge clk) begin
    if (mem_ready && mem_req.write) begin
      mem[idx] <= mem_req.wdata[31:0];
      if (mem_req.size == SZ_DUAL) mem[idx+6'h1] <= mem_req.wdata[63:32];
    end
  end
endmodule
`default_nettype wire

// File: lsx_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lsx_monitor
  import lsx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic [XLEN-1:0] set_addr,
  input wire size_t set_size,
  input wire logic clr,
  input wire logic snoop_valid,
  input wire logic [XLEN-1:0] snoop_addr,
  output logic open,
  output logic [XLEN-1:0] addr,
  output size_t size
);

  logic open_q;
  logic [XLEN-1:0] addr_q;
  size_t size_q;

  // A foreign access to the guarded word breaks the reservation.
  function automatic logic same_word(input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
    same_word = (a[XLEN-1:2] == b[XLEN-1:2]);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open_q <= 1'b0;
    end else if (set) begin
      open_q <= 1'b1;
    end else if (clr) begin
      open_q <= 1'b0;
    end else if (snoop_valid && same_word(snoop_addr, addr_q)) begin
      open_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= RESET_WORD;
      size_q <= SZ_WORD;
    end else if (set) begin
      addr_q <= set_addr;
      size_q <= set_size;
    end
  end

  assign open = open_q;
  assign addr = addr_q;
  assign size = size_q;

endmodule
`default_nettype wire

// File: lsx_pkg.sv
package lsx_pkg;

  localparam int XLEN = 32;
  localparam int REG_IDX_W = 4;
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_PC = 4'hF;

  localparam int IMM_W = 13;
  localparam logic signed [12:0] OFS_PLAIN_MIN = -13'sd255;
  localparam logic signed [12:0] OFS_PLAIN_MAX = 13'sd4095;
  localparam logic signed [12:0] OFS_INDEX_MIN = -13'sd255;
  localparam logic signed [12:0] OFS_INDEX_MAX = 13'sd255;
  localparam logic signed [12:0] OFS_DUAL_MIN = -13'sd1020;
  localparam logic signed [12:0] OFS_DUAL_MAX = 13'sd1020;
  localparam logic signed [12:0] OFS_EXCL_MIN = 13'sd0;
  localparam logic signed [12:0] OFS_EXCL_MAX = 13'sd1020;

  localparam logic [XLEN-1:0] STATUS_OK = 32'h0000_0000;
  localparam logic [XLEN-1:0] STATUS_FAIL = 32'h0000_0001;
  localparam logic [XLEN-1:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DUAL} size_t;
  typedef enum logic [1:0] {AM_OFFSET, AM_PRE, AM_POST} amode_t;
  typedef enum logic [1:0] {OP_LOAD, OP_STORE, OP_LOAD_EXCL, OP_STORE_EXCL} op_t;

  typedef struct packed {
    op_t op;
    size_t size;
    logic sign_ext;
    amode_t amode;
    logic [IMM_W-1:0] offset;
    logic [REG_IDX_W-1:0] base_reg;
    logic [REG_IDX_W-1:0] data_reg;
    logic [REG_IDX_W-1:0] second_data_reg;
    logic [REG_IDX_W-1:0] status_reg;
    logic [XLEN-1:0] base_val;
    logic [XLEN-1:0] data_val;
    logic [XLEN-1:0] second_data_val;
  } req_t;

  typedef struct packed {
    logic [XLEN-1:0] addr;
    logic write;
    size_t size;
    logic [2*XLEN-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic wr_en;
    logic [REG_IDX_W-1:0] idx;
    logic [XLEN-1:0] val;
  } wb_t;

endpackage
